//--- src/avwf_pkg.sv
// Package with word layout, range codes and timing constants
package avwf_pkg;
   localparam int AVWF_WORD_W = 16;
   localparam int AVWF_MSB = 15;
   localparam logic signed [15:0] AVWF_CODE_OVERFLOW = 16'sh7fff;
   localparam logic signed [15:0] AVWF_CODE_OVR_TOP = 16'sh7eff;
   localparam logic signed [15:0] AVWF_CODE_UNDERFLOW = 16'sh8000;
   localparam logic signed [15:0] AVWF_CODE_UND_BOT = 16'sh8100;
   localparam logic signed [15:0] AVWF_RESET_WORD = 16'sh0000;
   // Ends of the rated range, beyond them lies over- or underrange
   localparam logic signed [15:0] AVWF_RATED_TOP = 16'sh6c00;
   localparam logic signed [15:0] AVWF_RATED_BOT = 16'sh9400;
   localparam int AVWF_RES_DEFAULT = 16;
   localparam int AVWF_CONV_NS = 100;
   localparam int AVWF_CLK_NS = 25;
   localparam int AVWF_CONV_CYC =
      (AVWF_CONV_NS + AVWF_CLK_NS - 1) / AVWF_CLK_NS;
   typedef enum logic [1:0] {
      AVWF_IDLE = 2'b00,
      AVWF_LOAD = 2'b01,
      AVWF_CONV = 2'b10
   } avwf_state_t;
   typedef struct packed {
      logic overflow;
      logic overrange;
      logic underrange;
      logic underflow;
   } avwf_flags_t;
endpackage

//--- src/avwf_format.sv
// Combinational word formatter: saturation and left justification
`timescale 1ns/10ps
`default_nettype none
module avwf_format
   import avwf_pkg::*;
#(
   parameter int RES = AVWF_RES_DEFAULT
) (
   input wire logic signed [15:0] value_in,
   output logic signed [15:0] word_out,
   output avwf_flags_t flags
);
   localparam logic [15:0] LOW_MASK = 16'hffff << (16 - RES);
   logic signed [15:0] sat;
   always_comb begin
      flags = '0;
      sat = value_in;
      // Beyond the band clamp rather than wrap
      if (value_in > AVWF_CODE_OVR_TOP) begin
         sat = AVWF_CODE_OVERFLOW;
         flags.overflow = 1'b1;
      end else if (value_in < AVWF_CODE_UND_BOT) begin
         sat = AVWF_CODE_UNDERFLOW;
         flags.underflow = 1'b1;
      end else if (value_in > AVWF_RATED_TOP) begin
         flags.overrange = 1'b1;
      end else if (value_in < AVWF_RATED_BOT) begin
         flags.underrange = 1'b1;
      end
      // Codes keep full width; normal values drop unused low bits
      if (flags.overflow || flags.underflow)
         word_out = sat;
      else
         word_out = sat & LOW_MASK;
   end
endmodule
`default_nettype wire

//--- src/avwf_top.sv
// Analog output word formatter and conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module avwf_top
   import avwf_pkg::*;
#(
   parameter int RES = AVWF_RES_DEFAULT,
   parameter int CONV_CYC = AVWF_CONV_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic msg_valid,
   input wire logic signed [15:0] msg_value,
   input wire logic msg_end,
   output logic signed [15:0] dac_word,
   output logic dac_load,
   output logic dac_start,
   output logic conv_busy,
   output logic conv_done,
   output logic signed [15:0] readback_word,
   output avwf_flags_t range_flags
);
   // Period bound keeps the conversion check a short fixed delay
   if (RES < 8 || RES > AVWF_WORD_W) begin : g_bad_res
      $error("RES must be 8 to 16");
   end
   if (CONV_CYC < 1 || CONV_CYC > 256) begin : g_bad_conv
      $error("CONV_CYC must be 1 to 256");
   end

   avwf_state_t state, next_state;
   logic signed [15:0] mem, next_mem;
   logic pend, next_pend;
   logic [15:0] cnt, next_cnt;
   logic signed [15:0] fmt_word;
   avwf_flags_t fmt_flags;
   logic signed [15:0] next_dac_word;
   logic next_dac_load, next_dac_start, next_busy, next_done;
   avwf_flags_t next_flags;

   // Formatter encodes the memory value for the converter; readback takes the same formatted word that is loaded
   avwf_format #(.RES(RES)) u_fmt (
      .value_in(mem),
      .word_out(fmt_word),
      .flags(fmt_flags)
   );

   always_comb begin
      next_state = state;
      next_mem = mem;
      next_pend = pend;
      next_cnt = cnt;
      next_dac_word = dac_word;
      next_dac_load = 1'b0;
      next_dac_start = 1'b0;
      next_busy = conv_busy;
      next_done = 1'b0;
      next_flags = range_flags;
      // Interface writes the internal memory; last value wins
      if (msg_valid)
         next_mem = msg_value;
      // A message end during a conversion is kept, not dropped
      if (msg_end)
         next_pend = 1'b1;
      case (state)
         AVWF_IDLE: begin
            if (pend || msg_end) begin
               next_pend = 1'b0;
               next_state = AVWF_LOAD;
               next_busy = 1'b1;
            end
         end
         AVWF_LOAD: begin
            next_dac_word = fmt_word;
            next_flags = fmt_flags;
            next_dac_load = 1'b1;
            next_dac_start = 1'b1;
            next_cnt = 16'(CONV_CYC - 1);
            next_state = AVWF_CONV;
         end
         AVWF_CONV: begin
            // Single channel: one conversion ends the cycle
            if (cnt == 16'h0000) begin
               next_state = AVWF_IDLE;
               next_busy = 1'b0;
               next_done = 1'b1;
            end else begin
               next_cnt = cnt - 16'h0001;
            end
         end
         default: next_state = AVWF_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= AVWF_IDLE;
         mem <= AVWF_RESET_WORD;
         pend <= 1'b0;
         cnt <= 16'h0000;
         dac_word <= AVWF_RESET_WORD;
         dac_load <= 1'b0;
         dac_start <= 1'b0;
         conv_busy <= 1'b0;
         conv_done <= 1'b0;
         range_flags <= '0;
         readback_word <= AVWF_RESET_WORD;
      end else begin
         state <= next_state;
         mem <= next_mem;
         pend <= next_pend;
         cnt <= next_cnt;
         dac_word <= next_dac_word;
         dac_load <= next_dac_load;
         dac_start <= next_dac_start;
         conv_busy <= next_busy;
         conv_done <= next_done;
         range_flags <= next_flags;
         readback_word <= next_dac_word;
      end
   end

   localparam logic [15:0] LOW_BITS = ~(16'hffff << (16 - RES));

   AST_LOAD_AFTER_END:
   assert property (@(posedge clk) disable iff (rst)
      (state == AVWF_IDLE && msg_end) |-> ##2 dac_load)
   else $error("no load two cycles after message end");

   AST_START_WITH_LOAD:
   assert property (@(posedge clk) disable iff (rst)
      dac_load |-> dac_start && conv_busy)
   else $error("load without start");

   AST_ONE_PERIOD:
   assert property (@(posedge clk) disable iff (rst)
      dac_start |-> ##(CONV_CYC) conv_done)
   else $error("conversion period wrong");

   AST_DONE_CLEARS_BUSY:
   assert property (@(posedge clk) disable iff (rst)
      conv_done |-> !conv_busy)
   else $error("busy after done");

   AST_LOW_ZERO:
   assert property (@(posedge clk) disable iff (rst)
      (dac_load && !range_flags.overflow && !range_flags.underflow)
      |-> (dac_word & LOW_BITS) == 16'h0000)
   else $error("unused low bits not zero");

   AST_SATURATE:
   assert property (@(posedge clk) disable iff (rst)
      (state == AVWF_LOAD && mem > AVWF_CODE_OVR_TOP)
      |=> dac_word == AVWF_CODE_OVERFLOW && range_flags.overflow)
   else $error("no saturation to overflow");

   AST_OVERFLOW_CODE:
   assert property (@(posedge clk) disable iff (rst)
      range_flags.overflow |-> dac_word == 16'sh7fff)
   else $error("overflow flag with wrong code");

   AST_SIGN_KEPT:
   assert property (@(posedge clk) disable iff (rst)
      (state == AVWF_LOAD) |=> dac_word[AVWF_MSB] == $past(mem[15]))
   else $error("sign bit lost");

   AST_BUSY_AFTER_END:
   assert property (@(posedge clk) disable iff (rst)
      (state == AVWF_IDLE && msg_end) |=> conv_busy)
   else $error("accepted message end did not raise busy");

   AST_PEND_SERVED:
   assert property (@(posedge clk) disable iff (rst)
      (state == AVWF_IDLE && pend) |=> state == AVWF_LOAD)
   else $error("pending message end not served");

   AST_WORD_HELD:
   assert property (@(posedge clk) disable iff (rst)
      (!dac_load && !$past(rst)) |-> $stable(dac_word))
   else $error("converter word changed without load");

   AST_DONE_PULSE:
   assert property (@(posedge clk) disable iff (rst)
      conv_done |=> !conv_done)
   else $error("done longer than one cycle");

   AST_BUSY_WHILE_CONV:
   assert property (@(posedge clk) disable iff (rst)
      (state == AVWF_CONV) |-> conv_busy)
   else $error("not busy during conversion");

   AST_UNDERFLOW_CODE:
   assert property (@(posedge clk) disable iff (rst)
      range_flags.underflow |-> dac_word == AVWF_CODE_UNDERFLOW)
   else $error("underflow flag with wrong code");

   AST_FLAGS_ONEHOT:
   assert property (@(posedge clk) disable iff (rst)
      $onehot0(range_flags))
   else $error("more than one range flag");

   AST_READBACK:
   assert property (@(posedge clk) disable iff (rst)
      readback_word == dac_word)
   else $error("readback differs from converter word");

   COV_CONVERT: cover property (@(posedge clk) dac_start ##[1:20] conv_done);
   COV_OVERFLOW: cover property (@(posedge clk) dac_load
      && range_flags.overflow);
   COV_PENDING: cover property (@(posedge clk) conv_busy && msg_end);
   COV_UNDERFLOW: cover property (@(posedge clk) dac_load
      && range_flags.underflow);
endmodule
`default_nettype wire

//--- tb/avwf_iface_model.sv
// Interface-side model handing one value and a message end to the block
`timescale 1ns/10ps
`default_nettype none
module avwf_iface_model (
   input wire logic clk,
   output logic msg_valid,
   output logic signed [15:0] msg_value,
   output logic msg_end
);
   initial begin
      msg_valid = 1'b0;
      msg_value = 16'h5a5a;
      msg_end = 1'b0;
   end
   // Gap sets the idle cycles before the value and message end are driven
   task automatic send(input logic signed [15:0] v, input int gap);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      msg_valid <= 1'b1;
      msg_value <= v;
      msg_end <= 1'b1;
      @(posedge clk);
      msg_valid <= 1'b0;
      msg_end <= 1'b0;
      // Released data must not look like a still valid value
      msg_value <= ~v;
   endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the word formatter and conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import avwf_pkg::*;
   localparam int RES = 12;
   logic clk, rst, msg_valid, msg_end, dac_load, dac_start;
   logic conv_busy, conv_done;
   logic signed [15:0] msg_value, dac_word, readback_word;
   avwf_flags_t range_flags;
   int num_errors = 0;
   int checks_done = 0;
   int t_load, t_done, n_load, n_busy;
   avwf_top #(.RES(RES)) dut_u (.clk(clk), .rst(rst),
      .msg_valid(msg_valid), .msg_value(msg_value), .msg_end(msg_end),
      .dac_word(dac_word), .dac_load(dac_load), .dac_start(dac_start),
      .conv_busy(conv_busy), .conv_done(conv_done),
      .readback_word(readback_word), .range_flags(range_flags));
   avwf_iface_model far_u (.clk(clk), .msg_valid(msg_valid),
      .msg_value(msg_value), .msg_end(msg_end));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic cmp_word(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_cnt(input string what, input int exp, input int got);
      checks_done++;
      if (got != exp) begin
         num_errors++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // Sample c sits just before edge c+1 after the one taking msg_end
   task automatic measure(input int span);
      t_load = -1;
      t_done = -1;
      n_load = 0;
      n_busy = 0;
      for (int c = 0; c < span; c++) begin
         @(negedge clk);
         if (conv_busy === 1'b1) n_busy++;
         cmp_word("dac_start", {15'h0, dac_load}, {15'h0, dac_start});
         if (dac_load === 1'b1) begin
            n_load++;
            if (t_load < 0) t_load = c;
         end
         if (conv_done === 1'b1 && t_done < 0) t_done = c;
      end
   endtask
   task automatic test_formats();
      logic signed [15:0] vals [6] = '{16'sh1237, 16'sh7eff, 16'sh7f00,
                                       16'shffff, 16'sh8100, 16'sh80ff};
      // Expected words hold for a 12-bit converter; the flags hold for any resolution
      logic [15:0] words [6] = '{16'h1230, 16'h7ef0, 16'h7fff,
                                 16'hfff0, 16'h8100, 16'h8000};
      logic [3:0] flags [6] = '{4'h0, 4'h4, 4'h8, 4'h0, 4'h2, 4'h1};
      foreach (vals[i]) begin
         far_u.send(vals[i], i);
         measure(12);
         cmp_word("dac_word", words[i], dac_word);
         cmp_word("readback", words[i], readback_word);
         cmp_word("range_flags", {12'h000, flags[i]},
                  {12'h000, range_flags});
         cmp_cnt("load cycle", 1, t_load);
         cmp_cnt("done cycle", 1 + AVWF_CONV_CYC, t_done);
         cmp_cnt("busy cycles", 1 + AVWF_CONV_CYC, n_busy);
      end
   endtask
   // A second message end while busy must run after the first conversion
   task automatic test_pending();
      far_u.send(16'sh2345, 0);
      fork
         far_u.send(16'sh4567, 0);
      join_none
      measure(20);
      cmp_cnt("load count", 2, n_load);
      cmp_word("dac_word", 16'h4560, dac_word);
      cmp_cnt("busy cycles", 2 * (1 + AVWF_CONV_CYC), n_busy);
   endtask
   task automatic end_of_test();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      test_formats();
      test_pending();
      end_of_test();
   end
   initial begin
      repeat (1000) @(posedge clk);
      num_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
